/* File: ptreg_top.v */
// Egress timestamp, pin direction and trigger interrupt register slice.
// Assumes the register port is synchronous to CLK and accesses are single cycle.
// What this block does
// - Sync low word holds egress nanoseconds 15:0.
// - Sync high word: seconds 1:0 in bits 15-14, nanoseconds 29:16 in 13-0.
// - Peer delay reply low word holds egress nanoseconds 15:0.
// - Peer delay reply high word: seconds 1:0 at 15-14, nanoseconds 29:16 at 13-0.
// - Pin levels read in bits 6:0, upper bits zero.
// - Direction bit 0 selects trigger output, 1 timestamp input; reset zero.
// - Trigger unit done or error sets its flag; units 12..1 on bits 11:0.
// - Writing one clears a flag; writing zero leaves it.
// - Chip interrupt status bit 10 is the OR of all twelve flags.
// - Twelve mask bits, reset zero, enable each unit interrupt.
// - Chip interrupt enable bit 10 is the OR of all twelve mask bits.
//
// Decided for this implementation: the address-and-strobe port.
`include "ptreg_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module ptreg_top #(
	parameter NUM_PINS = `PTREG_NUM_PINS,
	parameter NUM_TRIG = `PTREG_NUM_TRIG
) (
	input  wire                      CLK,
	input  wire                      NRST,
	input  wire                      CE,
	input  wire [`PTREG_ADDR_W-1:0]  ADDR,
	input  wire [15:0]               WDATA,
	input  wire                      WR,
	input  wire                      RD,
	output reg  [15:0]               RDATA,
	input  wire                      SYNC_SENT,
	input  wire                      PDLY_SENT,
	input  wire [1:0]                EGRESS_SEC,
	input  wire [29:0]               EGRESS_NS,
	input  wire [NUM_PINS-1:0]       PIN_LEVELS,
	output wire [NUM_PINS-1:0]       PIN_DIRECTION,
	input  wire [NUM_TRIG-1:0]       TRIG_EVENT,
	output wire [15:0]               CHIP_INTERRUPT_STATUS,
	output wire [15:0]               CHIP_INTERRUPT_ENABLE,
	output wire                      IRQ
);

	reg  [15:0]         sync_low;
	reg  [15:0]         sync_high;
	reg  [15:0]         pdly_low;
	reg  [15:0]         pdly_high;
	reg  [NUM_PINS-1:0] pin_dir;
	reg  [NUM_TRIG-1:0] trig_flags;
	reg  [NUM_TRIG-1:0] trig_mask;
	reg  [15:0]         next_rdata;
	wire [15:0]         egress_high;
	wire                flags_any;
	wire                mask_any;

	// Returns high when a write strobe targets the given offset.
	function wr_hit;
		input                     strobe;
		input [`PTREG_ADDR_W-1:0] addr;
		input [`PTREG_ADDR_W-1:0] ofs;
		begin
			wr_hit = strobe && (addr == ofs);
		end
	endfunction

	assign egress_high = {EGRESS_SEC, EGRESS_NS[29:16]};

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sync_low  <= `PTREG_TIME_RESET;
			sync_high <= `PTREG_TIME_RESET;
			pdly_low  <= `PTREG_TIME_RESET;
			pdly_high <= `PTREG_TIME_RESET;
		end else if (CE) begin
			// A frame capture takes priority over a host write in the same cycle.
			if (SYNC_SENT) begin
				sync_low  <= EGRESS_NS[15:0];
				sync_high <= egress_high;
			end else begin
				if (wr_hit(WR, ADDR, `PTREG_SYNC_LOW_OFS))
					sync_low <= WDATA;
				if (wr_hit(WR, ADDR, `PTREG_SYNC_HIGH_OFS))
					sync_high <= WDATA;
			end
			if (PDLY_SENT) begin
				pdly_low  <= EGRESS_NS[15:0];
				pdly_high <= egress_high;
			end else begin
				if (wr_hit(WR, ADDR, `PTREG_PDLY_LOW_OFS))
					pdly_low <= WDATA;
				if (wr_hit(WR, ADDR, `PTREG_PDLY_HIGH_OFS))
					pdly_high <= WDATA;
			end
		end
	end

	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pin_dir   <= `PTREG_PIN_DIR_RESET;
			trig_mask <= `PTREG_TRIG_RESET;
		end else if (CE) begin
			if (wr_hit(WR, ADDR, `PTREG_PIN_DIR_OFS))
				pin_dir <= WDATA[NUM_PINS-1:0];
			if (wr_hit(WR, ADDR, `PTREG_TRIG_MASK_OFS))
				trig_mask <= WDATA[NUM_TRIG-1:0];
		end
	end

	// Each flag is sticky; a new event in the clearing cycle keeps it set.
	genvar i;
	generate
		for (i = 0; i < NUM_TRIG; i = i + 1) begin : g_flag
			always @(posedge CLK or negedge NRST) begin
				if (!NRST) begin
					trig_flags[i] <= 1'b0;
				end else if (CE) begin
					if (TRIG_EVENT[i])
						trig_flags[i] <= 1'b1;
					else if (wr_hit(WR, ADDR, `PTREG_TRIG_FLAGS_OFS) && WDATA[i])
						trig_flags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign flags_any = |trig_flags;
	assign mask_any  = |trig_mask;
	assign CHIP_INTERRUPT_STATUS = {5'h00, flags_any, 10'h000};
	assign CHIP_INTERRUPT_ENABLE = {5'h00, mask_any, 10'h000};
	assign IRQ = |(trig_flags & trig_mask);
	assign PIN_DIRECTION = pin_dir;

	always @* begin
		next_rdata = 16'h0000;
		case (ADDR)
			`PTREG_SYNC_LOW_OFS:   next_rdata = sync_low;
			`PTREG_SYNC_HIGH_OFS:  next_rdata = sync_high;
			`PTREG_PDLY_LOW_OFS:   next_rdata = pdly_low;
			`PTREG_PDLY_HIGH_OFS:  next_rdata = pdly_high;
			`PTREG_PIN_LEVELS_OFS: next_rdata[NUM_PINS-1:0] = PIN_LEVELS;
			`PTREG_PIN_DIR_OFS:    next_rdata[NUM_PINS-1:0] = pin_dir;
			`PTREG_TRIG_FLAGS_OFS: next_rdata[NUM_TRIG-1:0] = trig_flags;
			`PTREG_TRIG_MASK_OFS:  next_rdata[NUM_TRIG-1:0] = trig_mask;
			default:               next_rdata = 16'h0000;
		endcase
	end

	// Read data stands only in the cycle after the read strobe.
	always @(posedge CLK or negedge NRST) begin
		if (!NRST)
			RDATA <= 16'h0000;
		else if (CE)
			RDATA <= RD ? next_rdata : 16'h0000;
	end

endmodule
`default_nettype wire

/* File: ptreg_defines.vh */
// Register offsets, field positions and reset values of the egress timestamp and
// trigger register slice. Assumes a 16-bit register port with byte offsets.
`ifndef PTREG_DEFINES_VH
`define PTREG_DEFINES_VH
`define PTREG_ADDR_W              12
`define PTREG_SYNC_LOW_OFS        12'h64c
`define PTREG_SYNC_HIGH_OFS       12'h64e
`define PTREG_PDLY_LOW_OFS        12'h650
`define PTREG_PDLY_HIGH_OFS       12'h652
`define PTREG_PIN_LEVELS_OFS      12'h680
`define PTREG_PIN_DIR_OFS         12'h682
`define PTREG_TRIG_FLAGS_OFS      12'h688
`define PTREG_TRIG_MASK_OFS       12'h68a
`define PTREG_HIGH_SEC_MSB        15
`define PTREG_HIGH_SEC_LSB        14
`define PTREG_HIGH_NS_MSB         13
`define PTREG_NUM_PINS            7
`define PTREG_NUM_TRIG            12
`define PTREG_CHIP_IRQ_BIT        10
`define PTREG_TIME_RESET          16'h0000
`define PTREG_PIN_DIR_RESET       7'h00
`define PTREG_TRIG_RESET          12'h000
`endif

/* File: ptreg_assertions.sv */
// Concurrent checks on the ports of the egress timestamp and trigger register slice.
// Assumes one clock, single-cycle register strobes and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module ptreg_chk #(
	parameter NUM_PINS = 7,
	parameter NUM_TRIG = 12
) (
	input wire logic                CLK,
	input wire logic                NRST,
	input wire logic                CE,
	input wire logic [11:0]         ADDR,
	input wire logic [15:0]         WDATA,
	input wire logic                WR,
	input wire logic                RD,
	input wire logic [15:0]         RDATA,
	input wire logic [NUM_PINS-1:0] PIN_LEVELS,
	input wire logic [NUM_PINS-1:0] PIN_DIRECTION,
	input wire logic [NUM_TRIG-1:0] TRIG_EVENT,
	input wire logic [15:0]         CHIP_INTERRUPT_STATUS,
	input wire logic [15:0]         CHIP_INTERRUPT_ENABLE,
	input wire logic                IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence rd_at(a);
		RD && CE && ADDR == a;
	endsequence
	sequence clear_all;
		CE && WR && ADDR == 12'h688 && WDATA[11:0] == 12'hfff && TRIG_EVENT == 0;
	endsequence
	chk_rdata_idle: assert property (CE && !RD |=> RDATA == 16'h0000)
		else $error("read data not idle");
	chk_pin_read: assert property (rd_at(12'h680) |=> RDATA == $past(PIN_LEVELS))
		else $error("pin levels read wrong");
	chk_dir_read: assert property (rd_at(12'h682) |=> RDATA == PIN_DIRECTION)
		else $error("direction read wrong");
	chk_mask_or: assert property (rd_at(12'h68a) |=> (|RDATA) == CHIP_INTERRUPT_ENABLE[10])
		else $error("enable summary wrong");
	chk_event_sets: assert property (CE && |TRIG_EVENT |=> CHIP_INTERRUPT_STATUS[10])
		else $error("event did not set flag");
	chk_flag_clear: assert property (clear_all |=> !CHIP_INTERRUPT_STATUS[10])
		else $error("flags not cleared");
	chk_status_rsvd: assert property ((CHIP_INTERRUPT_STATUS & 16'hfbff) == 0)
		else $error("status reserved bits set");
	chk_enable_rsvd: assert property ((CHIP_INTERRUPT_ENABLE & 16'hfbff) == 0)
		else $error("enable reserved bits set");
	chk_irq_gate: assert property (IRQ |-> CHIP_INTERRUPT_STATUS[10] && CHIP_INTERRUPT_ENABLE[10])
		else $error("interrupt without enabled flag");
endmodule
bind ptreg_top ptreg_chk #(.NUM_PINS(NUM_PINS), .NUM_TRIG(NUM_TRIG)) ptreg_chk_inst (.CLK(CLK),
	.NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.PIN_LEVELS(PIN_LEVELS), .PIN_DIRECTION(PIN_DIRECTION), .TRIG_EVENT(TRIG_EVENT), .IRQ(IRQ),
	.CHIP_INTERRUPT_STATUS(CHIP_INTERRUPT_STATUS), .CHIP_INTERRUPT_ENABLE(CHIP_INTERRUPT_ENABLE));
`default_nettype wire

/* File: ptreg_top_tb_top.sv */
// Self-checking bench for the register slice; expected read values are queued and compared when the read data arrives.
// Assumes the design and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ptreg_top_tb_top;
	reg         CLK, NRST, CE, WR, RD, SYNC_SENT, PDLY_SENT;
	reg         rd_p = 1'b0;
	reg  [11:0] ADDR, TRIG_EVENT, t;
	reg  [15:0] WDATA;
	reg  [1:0]  EGRESS_SEC;
	reg  [29:0] EGRESS_NS;
	reg  [6:0]  PIN_LEVELS;
	reg  [31:0] r;
	wire [15:0] RDATA, CHIP_INTERRUPT_STATUS, CHIP_INTERRUPT_ENABLE;
	wire [6:0]  PIN_DIRECTION;
	wire        IRQ;
	logic [15:0] q[$];
	logic [11:0] ofs[9] = '{12'h64c, 12'h64e, 12'h650, 12'h652, 12'h680, 12'h682, 12'h688, 12'h68a,
		12'h654};
	int failures, check_count;
	ptreg_top ptreg_top_inst (.CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .SYNC_SENT(SYNC_SENT), .PDLY_SENT(PDLY_SENT),
		.EGRESS_SEC(EGRESS_SEC), .EGRESS_NS(EGRESS_NS), .PIN_LEVELS(PIN_LEVELS),
		.PIN_DIRECTION(PIN_DIRECTION), .TRIG_EVENT(TRIG_EVENT), .IRQ(IRQ),
		.CHIP_INTERRUPT_STATUS(CHIP_INTERRUPT_STATUS), .CHIP_INTERRUPT_ENABLE(CHIP_INTERRUPT_ENABLE));
	initial begin
		CLK = 0;
		forever #5 CLK = ~CLK;
	end
	task check(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge CLK);
		WR <= 1; ADDR <= a; WDATA <= d;
		@(posedge CLK);
		WR <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e);
		@(posedge CLK);
		RD <= 1; ADDR <= a; q.push_back(e);
		@(posedge CLK);
		RD <= 0;
	endtask
	always @(posedge CLK) begin
		if (rd_p) check(RDATA, q.pop_front());
		rd_p <= RD;
	end
	initial begin
		#20000 failures++;
		give_verdict;
	end
	initial begin
		{CE, WR, RD, SYNC_SENT, PDLY_SENT, NRST} = 6'h20;
		{ADDR, TRIG_EVENT, WDATA, EGRESS_SEC, EGRESS_NS} = 0;
		r = $urandom(35591);
		PIN_LEVELS = r[6:0];
		repeat (3) @(posedge CLK);
		NRST <= 1;
		foreach (ofs[i]) rd(ofs[i], i == 4 ? {9'h000, PIN_LEVELS} : 16'h0000);
		$display("reset test done");
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK);
			r = $urandom;
			{EGRESS_SEC, EGRESS_NS} <= r; SYNC_SENT <= k == 0; PDLY_SENT <= k == 1;
			@(posedge CLK);
			SYNC_SENT <= 0; PDLY_SENT <= 0;
			rd(k ? 12'h650 : 12'h64c, r[15:0]);
			rd(k ? 12'h652 : 12'h64e, {r[31:30], r[29:16]});
		end
		wr(12'h64e, r[31:16]); rd(12'h64e, r[31:16]); wr(12'h654, 16'hffff); rd(12'h654, 16'h0000);
		wr(12'h682, 16'hffff); rd(12'h682, 16'h007f); wr(12'h68a, 16'hffff); rd(12'h68a, 16'h0fff);
		#1 check(PIN_DIRECTION, 16'h007f);
		check(CHIP_INTERRUPT_ENABLE, 16'h0400);
		$display("capture and write test done");
		t = r[11:0] | 12'h001;
		@(posedge CLK) TRIG_EVENT <= t;
		@(posedge CLK) TRIG_EVENT <= 0;
		rd(12'h688, {4'h0, t}); wr(12'h688, 16'h0000); wr(12'h688, {4'hf, t & 12'hffe});
		#1 check(IRQ, 16'h0001);
		check(CHIP_INTERRUPT_STATUS, 16'h0400);
		rd(12'h688, 16'h0001); wr(12'h68a, 16'h0000);
		#1 check(IRQ, 16'h0000);
		check(CHIP_INTERRUPT_ENABLE, 16'h0000);
		wr(12'h688, 16'h0001);
		#1 check(CHIP_INTERRUPT_STATUS, 16'h0000);
		$display("trigger interrupt test done");
		give_verdict;
	end
endmodule
`default_nettype wire
